/* File: src/rtcac_defs.vh */
`ifndef RTCAC_DEFS_VH
`define RTCAC_DEFS_VH
// Memory geometry
`define RTCAC_BLOCKS     8'd80
`define RTCAC_CNT_BLK    8'd79
`define RTCAC_BLK_W      32
// UID generation code
`define RTCAC_GEN_CODE   2'b01
// Request flag positions
`define RTCAC_FB_INV     2
`define RTCAC_FB_AFI     4
`define RTCAC_FB_SEL     4
`define RTCAC_FB_ADR     5
`define RTCAC_FB_OPT     6
// Response flags
`define RTCAC_FL_OK      8'h00
`define RTCAC_FL_ERR     8'h01
// Error codes
`define RTCAC_ERR_NSUP   8'h01
`define RTCAC_ERR_GEN    8'h0f
`define RTCAC_ERR_NAV    8'h10
`define RTCAC_ERR_LKD    8'h11
`define RTCAC_ERR_LCH    8'h12
`define RTCAC_ERR_LKF    8'h14
// Command codes
`define RTCAC_C_INV      8'h01
`define RTCAC_C_QUIET    8'h02
`define RTCAC_C_RD1      8'h20
`define RTCAC_C_WR1      8'h21
`define RTCAC_C_LOCK     8'h22
`define RTCAC_C_RDM      8'h23
`define RTCAC_C_SEL      8'h25
`define RTCAC_C_RTR      8'h26
`define RTCAC_C_WAFI     8'h27
`define RTCAC_C_LAFI     8'h28
`define RTCAC_C_WDSF     8'h29
`define RTCAC_C_LDSF     8'h2a
`define RTCAC_C_SYS      8'h2b
`define RTCAC_C_MSEC     8'h2c
`define RTCAC_C_RND      8'hb2
`define RTCAC_C_SETPW    8'hb3
`define RTCAC_C_SQP      8'hbc
`define RTCAC_C_RSIG     8'hbd
`define RTCAC_CUST_LO    8'ha0
`define RTCAC_CUST_HI    8'hdf
// Password identifiers
`define RTCAC_PID_RD     8'h01
`define RTCAC_PID_WR     8'h02
`define RTCAC_PID_PRV    8'h04
`define RTCAC_PID_DST    8'h08
`define RTCAC_PID_EAS    8'h10
// Delivered password values
`define RTCAC_PW_DEF_LO  32'h00000000
`define RTCAC_PW_DEF_HI  32'h0f0f0f0f
// Random generator seed
`define RTCAC_LFSR_SEED  16'hace1
// Tag states
`define RTCAC_ST_READY   2'd0
`define RTCAC_ST_SEL     2'd1
`define RTCAC_ST_QUIET   2'd2
`define RTCAC_ST_PQ      2'd3
// Stream modes
`define RTCAC_SM_IDLE    2'd0
`define RTCAC_SM_RD      2'd1
`define RTCAC_SM_SEC     2'd2
`define RTCAC_SM_SIG     2'd3
`endif

/* File: src/rtcac_mem.v */
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_defs.vh"
module rtcac_mem (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // Write side
  input  wire        we_in,
  input  wire        lock_we_in,
  input  wire [7:0]  waddr_in,
  input  wire [31:0] wdata_in,
  // Read side
  input  wire [7:0]  raddr_in,
  output wire [31:0] rdata_out,
  output wire        rlock_out
);
  reg [`RTCAC_BLK_W-1:0] mem_r [0:79];
  reg [79:0]             lock_r;
  wire [6:0]             wa;
  wire [6:0]             ra;

  assign wa = waddr_in[6:0];
  assign ra = raddr_in[6:0];
  // Core range-checks before reading
  assign rdata_out = mem_r[ra];
  assign rlock_out = lock_r[ra];

  // Non-volatile array, no reset
  always @(posedge clk_in) begin
    if (we_in)
      mem_r[wa] <= wdata_in;
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in)
      lock_r <= 80'h0;
    else if (lock_we_in)
      lock_r[wa] <= 1'b1;
  end
endmodule // rtcac_mem
`default_nettype wire

/* File: src/rtcac_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_defs.vh"
// Notes on behaviour
// RULE1: UID comes from parameters; no command writes it.
// RULE2: Protocol UID bit n sits at vector index n-1.
// RULE3: Tag type in UID bits 41-48, maker code in 49-56.
// RULE4: UID bits 37 and 36 hold the generation code.
// RULE5: Hidden 32-byte signature, read only by its own command.
// RULE6: Read, write and EAS/AFI passwords reset to 00h bytes.
// RULE7: Privacy and destroy passwords reset to 0Fh bytes.
// RULE8: Delivered: no page protection, privacy off, EAS/AFI guard off.
// RULE9: Quiet plus persistent: quiet now, persistent quiet at power-up.
// RULE10: No inventory reply in privacy or destroyed mode.
// RULE11: Single read of read-protected page needs read password.
// RULE12: Single write to protected page needs its password.
// RULE13: Block lock on protected page needs its password.
// RULE14: Block 79 is the counter: no lock, special read/write.
// RULE15: Multiple read needs read password if any block protected.
// RULE16: Reset-to-ready also leaves persistent quiet.
// RULE17: Option flag clear or set accepted on these commands.
// RULE18: AFI write and lock need EAS/AFI password when guarded.
// RULE19: Custom commands work in every addressing mode; non-addressed set password here is not supported, except privacy ID.
// RULE20: Standard commands follow vicinity protocol behaviour.
// RULE21: Reader puts maker code after custom command byte.
// RULE22: 80 blocks of 4 bytes; last is counter, zero, protect flag.
// RULE23: After a wrong password nothing runs until field drops.
// RULE24: Errors set the error flag, carry one-byte error code.
module rtcac_core #(
  parameter [7:0]   UID_TOP   = 8'ha5,   // Arbitrary value
  parameter [7:0]   MFG_CODE  = 8'h5a,   // Arbitrary value
  parameter [7:0]   TAG_TYPE  = 8'h3c,   // Arbitrary value
  parameter [39:0]  SERIAL    = 40'h0,   // Arbitrary value
  parameter [255:0] SIGNATURE = 256'h0   // Arbitrary value
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // Analog front end pins
  input  wire        field_in,
  input  wire        pq_retain_in,
  // Decoded request
  input  wire        cmd_valid_in,
  input  wire [7:0]  cmd_flags_in,
  input  wire [7:0]  cmd_code_in,
  input  wire [7:0]  cmd_mfg_in,
  input  wire [63:0] cmd_uid_in,
  input  wire [7:0]  cmd_blk_in,
  input  wire [7:0]  cmd_cnt_in,
  input  wire [31:0] cmd_data_in,
  input  wire [7:0]  cmd_pid_in,
  input  wire [7:0]  cmd_afi_in,
  // Configuration load
  input  wire        cfg_load_in,
  input  wire [7:0]  cfg_page_in,
  input  wire [1:0]  cfg_rd_counter_protect_flag_in,
  input  wire [1:0]  cfg_wr_counter_protect_flag_in,
  input  wire        cfg_privacy_in,
  input  wire        cfg_destroyed_in,
  input  wire        cfg_eas_counter_protect_flag_in,
  input  wire [7:0]  cfg_pid_in,
  input  wire [31:0] cfg_pwd_in,
  // Response
  output reg         rsp_valid_out,
  output reg  [7:0]  rsp_flags_out,
  output reg  [7:0]  rsp_err_out,
  output reg  [63:0] rsp_data_out,
  output reg  [15:0] rsp_aux_out,
  output reg         rsp_lock_out,
  output reg         rsp_last_out,
  // Status
  output wire [1:0]  tag_state_out,
  output wire        halted_out
);
  localparam [1:0] ST_READY = `RTCAC_ST_READY;
  localparam [1:0] ST_SEL   = `RTCAC_ST_SEL;
  localparam [1:0] ST_QUIET = `RTCAC_ST_QUIET;
  localparam [1:0] ST_PQ    = `RTCAC_ST_PQ;
  localparam [1:0] SM_IDLE  = `RTCAC_SM_IDLE;
  localparam [1:0] SM_RD    = `RTCAC_SM_RD;
  localparam [1:0] SM_SEC   = `RTCAC_SM_SEC;
  localparam [1:0] SM_SIG   = `RTCAC_SM_SIG;

  wire [63:0] uid;
  assign uid = {UID_TOP, MFG_CODE, TAG_TYPE, SERIAL[39:37],  // RULE1 RULE3
                `RTCAC_GEN_CODE, SERIAL[34:0]};              // RULE2 RULE4

  reg        f_m_r, f_s_r, f_d_r, r_m_r, r_s_r;
  reg  [1:0] st_r, sm_r;
  reg        pqp_r, halt_r, opt_r;
  reg        pw_rd_r, pw_wr_r, pw_eas_r, pw_prv_r;
  reg [31:0] pwd_rd_r, pwd_wr_r, pwd_eas_r, pwd_prv_r, pwd_dst_r;
  reg  [7:0] page_r, afi_r, dsfid_r, idx_r, left_r;
  reg  [1:0] rdprot_r, wrprot_r;
  reg        prv_r, dstr_r, easp_r, afi_lk_r, dsf_lk_r;
  reg [15:0] cnt_r, lfsr_r, rnd_r;
  reg        cprot_r;
  reg        we_r, lk_we_r;
  reg  [7:0] wa_r;
  reg [31:0] wd_r;
  reg [31:0] pw_ref;

  // Two-stage pin sync
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      f_m_r <= 1'b0;
      f_s_r <= 1'b0;
      f_d_r <= 1'b0;
      r_m_r <= 1'b0;
      r_s_r <= 1'b0;
    end else begin
      f_m_r <= field_in;
      f_s_r <= f_m_r;
      f_d_r <= f_s_r;
      r_m_r <= pq_retain_in;
      r_s_r <= r_m_r;
    end
  end

  wire power_up = f_s_r & ~f_d_r;

  // Request decode
  wire       inv   = cmd_flags_in[`RTCAC_FB_INV];
  wire       adr   = ~inv & cmd_flags_in[`RTCAC_FB_ADR];
  wire       selfl = ~inv & cmd_flags_in[`RTCAC_FB_SEL];
  wire       opt   = cmd_flags_in[`RTCAC_FB_OPT];
  wire       cust  = (cmd_code_in >= `RTCAC_CUST_LO) &
                     (cmd_code_in <= `RTCAC_CUST_HI);
  wire       mfg_ok = ~cust | (cmd_mfg_in == MFG_CODE);  // RULE21
  wire       uid_ok = ~adr | (cmd_uid_in == uid);
  wire       quiet  = (st_r == ST_QUIET) | (st_r == ST_PQ);
  // Same gate for standard and custom codes
  wire       mode_ok = (~quiet | adr) & (~selfl | st_r == ST_SEL); // RULE19
  wire       live = cmd_valid_in & f_s_r & ~halt_r & ~dstr_r &
                    (sm_r == SM_IDLE) & uid_ok & mfg_ok & mode_ok &
                    ~(prv_r & cmd_code_in != `RTCAC_C_RND);
  wire       afi_hit = ~cmd_flags_in[`RTCAC_FB_AFI] |
                       (cmd_afi_in == 8'h00) | (cmd_afi_in == afi_r);

  // Page protection checks
  wire [7:0] b     = cmd_blk_in;
  wire       hi    = b >= page_r;
  wire       rd_ok = ~rdprot_r[hi] | pw_rd_r;
  wire       wr_ok = wrprot_r[hi] ? pw_wr_r : rd_ok;
  wire       bad_b = b >= `RTCAC_BLOCKS;
  wire [8:0] last  = {1'b0, b} + {1'b0, cmd_cnt_in};
  wire       bad_m = last >= {1'b0, `RTCAC_BLOCKS};
  wire       mr_ok = pw_rd_r | ~((b < page_r & rdprot_r[0]) |
                     (last >= {1'b0, page_r} & rdprot_r[1]));
  wire       c_ok  = ~cprot_r | pw_rd_r;
  wire       m_cnt = last >= {1'b0, `RTCAC_CNT_BLK};
  wire [7:0] pq_b  = cmd_data_in[7:0];

  // Memory read path shared by single and multiple reads
  wire [7:0]  raddr = (sm_r == SM_IDLE) ? b : idx_r;
  wire [31:0] mrd;
  wire        mlk;
  wire        is_cnt = raddr == `RTCAC_CNT_BLK;
  wire [31:0] word = is_cnt ? {7'h0, cprot_r, 8'h00, cnt_r} : mrd; // RULE22
  wire        wlk  = mlk & ~is_cnt;

  rtcac_mem u_mem (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .we_in      (we_r),
    .lock_we_in (lk_we_r),
    .waddr_in   (wa_r),
    .wdata_in   (wd_r),
    .raddr_in   (raddr),
    .rdata_out  (mrd),
    .rlock_out  (mlk)
  );

  always @* begin
    case (cmd_pid_in)
      `RTCAC_PID_RD:  pw_ref = pwd_rd_r;
      `RTCAC_PID_WR:  pw_ref = pwd_wr_r;
      `RTCAC_PID_PRV: pw_ref = pwd_prv_r;
      `RTCAC_PID_DST: pw_ref = pwd_dst_r;
      default:        pw_ref = pwd_eas_r;
    endcase
  end
  wire pw_match = (cmd_data_in ^ {rnd_r, rnd_r}) == pw_ref;
  wire pid_ok   = (cmd_pid_in == `RTCAC_PID_RD) |
                  (cmd_pid_in == `RTCAC_PID_WR) |
                  (cmd_pid_in == `RTCAC_PID_PRV) |
                  (cmd_pid_in == `RTCAC_PID_DST) |
                  (cmd_pid_in == `RTCAC_PID_EAS);

  task send;
    input       err;
    input [7:0] ec;
    input [63:0] d;
    begin
      rsp_valid_out <= 1'b1;
      rsp_flags_out <= err ? `RTCAC_FL_ERR : `RTCAC_FL_OK;  // RULE24
      rsp_err_out   <= err ? ec : 8'h00;
      rsp_data_out  <= d;
      rsp_aux_out   <= {afi_r, dsfid_r};
      rsp_lock_out  <= 1'b0;
      rsp_last_out  <= 1'b1;
    end
  endtask

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= ST_READY;
      sm_r <= SM_IDLE;
      pqp_r <= 1'b0;
      halt_r <= 1'b0;
      opt_r <= 1'b0;
      pw_rd_r <= 1'b0;
      pw_wr_r <= 1'b0;
      pw_eas_r <= 1'b0;
      pw_prv_r <= 1'b0;
      pwd_rd_r <= `RTCAC_PW_DEF_LO; // RULE6
      pwd_wr_r <= `RTCAC_PW_DEF_LO; // RULE6
      pwd_eas_r <= `RTCAC_PW_DEF_LO; // RULE6
      pwd_prv_r <= `RTCAC_PW_DEF_HI; // RULE7
      pwd_dst_r <= `RTCAC_PW_DEF_HI; // RULE7
      page_r <= 8'h00;
      rdprot_r <= 2'b00; // RULE8
      wrprot_r <= 2'b00; // RULE8
      prv_r <= 1'b0; // RULE8
      easp_r <= 1'b0; // RULE8
      dstr_r <= 1'b0;
      afi_r <= 8'h00;
      dsfid_r <= 8'h00;
      afi_lk_r <= 1'b0;
      dsf_lk_r <= 1'b0;
      idx_r <= 8'h00;
      left_r <= 8'h00;
      cnt_r <= 16'h0000;
      cprot_r <= 1'b0;
      lfsr_r <= `RTCAC_LFSR_SEED;
      rnd_r <= 16'h0000;
      we_r <= 1'b0;
      lk_we_r <= 1'b0;
      wa_r <= 8'h00;
      wd_r <= 32'h0;
      rsp_valid_out <= 1'b0;
      rsp_flags_out <= 8'h00;
      rsp_err_out <= 8'h00;
      rsp_data_out <= 64'h0;
      rsp_aux_out <= 16'h0000;
      rsp_lock_out <= 1'b0;
      rsp_last_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      we_r <= 1'b0;
      lk_we_r <= 1'b0;
      lfsr_r <= {lfsr_r[14:0],
                 lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      if (~f_s_r) begin
        // Field gone: volatile state lost, marker kept
        st_r <= ST_READY;
        sm_r <= SM_IDLE;
        halt_r <= 1'b0;                                   // RULE23
        pw_rd_r <= 1'b0;
        pw_wr_r <= 1'b0;
        pw_eas_r <= 1'b0;
        pw_prv_r <= 1'b0;
      end else if (power_up) begin
        st_r <= (pqp_r & r_s_r) ? ST_PQ : ST_READY;       // RULE9
        pqp_r <= pqp_r & r_s_r;
      end else if (sm_r != SM_IDLE) begin
        // Streams block new requests until the last word
        send(1'b0, 8'h00, 64'h0);
        rsp_last_out <= left_r == 8'h00;
        if (sm_r == SM_RD) begin
          rsp_data_out <= {32'h0, word};
          rsp_lock_out <= opt_r & wlk;                    // RULE17
        end else if (sm_r == SM_SEC) begin
          rsp_lock_out <= wlk;                            // RULE20
        end else begin
          rsp_data_out <= {32'h0,
                           SIGNATURE[{idx_r[2:0], 5'b0} +: 32]}; // RULE5
        end
        idx_r <= idx_r + 8'h01;
        left_r <= left_r - 8'h01;
        if (left_r == 8'h00)
          sm_r <= SM_IDLE;
      end else if (live) begin
        opt_r <= opt;
        case (cmd_code_in)
          `RTCAC_C_INV: begin
            if (inv & ~prv_r & ~dstr_r & ~quiet & afi_hit) // RULE10 RULE20
              send(1'b0, 8'h00, uid);
          end
          `RTCAC_C_QUIET: begin
            if (adr)
              st_r <= ST_QUIET; // RULE20
          end
          `RTCAC_C_RD1: begin
            if (bad_b)
              send(1'b1, `RTCAC_ERR_NAV, 64'h0);
            else if (is_cnt ? ~c_ok : ~rd_ok)             // RULE11 RULE14
              send(1'b1, `RTCAC_ERR_GEN, 64'h0);
            else begin
              send(1'b0, 8'h00, {32'h0, word});
              rsp_lock_out <= opt & wlk;                  // RULE17
            end
          end
          `RTCAC_C_WR1: begin
            if (bad_b)
              send(1'b1, `RTCAC_ERR_NAV, 64'h0);
            else if (is_cnt) begin
              // 1 counts up; other values preset
              if (cmd_data_in == 32'h1 && c_ok) begin     // RULE14
                cnt_r <= cnt_r + 16'h0001;
                send(1'b0, 8'h00, 64'h0);
              end else if (cmd_data_in != 32'h1 && pw_wr_r) begin
                cnt_r <= cmd_data_in[15:0];
                cprot_r <= cmd_data_in[24];
                send(1'b0, 8'h00, 64'h0);
              end else
                send(1'b1, `RTCAC_ERR_GEN, 64'h0);
            end else if (mlk)
              send(1'b1, `RTCAC_ERR_LCH, 64'h0);
            else if (~wr_ok) // RULE12
              send(1'b1, `RTCAC_ERR_GEN, 64'h0);
            else begin
              we_r <= 1'b1;
              wa_r <= b;
              wd_r <= cmd_data_in;
              send(1'b0, 8'h00, 64'h0);
            end
          end
          `RTCAC_C_LOCK: begin
            if (bad_b)
              send(1'b1, `RTCAC_ERR_NAV, 64'h0);
            else if (is_cnt) // RULE14
              send(1'b1, `RTCAC_ERR_LKF, 64'h0);
            else if (mlk)
              send(1'b1, `RTCAC_ERR_LKD, 64'h0);
            else if (~wr_ok) // RULE13
              send(1'b1, `RTCAC_ERR_GEN, 64'h0);
            else begin
              lk_we_r <= 1'b1;
              wa_r <= b;
              send(1'b0, 8'h00, 64'h0);
            end
          end
          `RTCAC_C_RDM, `RTCAC_C_MSEC: begin
            if (bad_m)
              send(1'b1, `RTCAC_ERR_NAV, 64'h0);
            else if (cmd_code_in == `RTCAC_C_RDM &&
                     (~mr_ok || (m_cnt && ~c_ok)))        // RULE15
              send(1'b1, `RTCAC_ERR_GEN, 64'h0);
            else begin
              sm_r <= (cmd_code_in == `RTCAC_C_RDM) ? SM_RD : SM_SEC;
              idx_r <= b;
              left_r <= cmd_cnt_in;
            end
          end
          `RTCAC_C_SEL: begin
            if (adr) begin
              st_r <= ST_SEL; // RULE20
              send(1'b0, 8'h00, 64'h0);
            end
          end
          `RTCAC_C_RTR: begin
            st_r <= ST_READY; // RULE16
            pqp_r <= 1'b0;
            send(1'b0, 8'h00, 64'h0);
          end
          `RTCAC_C_WAFI, `RTCAC_C_LAFI: begin
            if (easp_r & ~pw_eas_r) // RULE18
              send(1'b1, `RTCAC_ERR_GEN, 64'h0);
            else if (afi_lk_r)
              send(1'b1, `RTCAC_ERR_LCH, 64'h0);
            else begin
              if (cmd_code_in == `RTCAC_C_WAFI)
                afi_r <= pq_b;
              else
                afi_lk_r <= 1'b1;
              send(1'b0, 8'h00, 64'h0);
            end
          end
          `RTCAC_C_WDSF, `RTCAC_C_LDSF: begin
            if (dsf_lk_r)
              send(1'b1, `RTCAC_ERR_LCH, 64'h0);
            else begin
              if (cmd_code_in == `RTCAC_C_WDSF)
                dsfid_r <= pq_b;
              else
                dsf_lk_r <= 1'b1;
              send(1'b0, 8'h00, 64'h0);
            end
          end
          `RTCAC_C_SYS: send(1'b0, 8'h00, uid);           // RULE20
          `RTCAC_C_RND: begin
            rnd_r <= lfsr_r;
            send(1'b0, 8'h00, {48'h0, lfsr_r});
          end
          `RTCAC_C_SETPW: begin
            if (~pid_ok || (~adr && ~selfl &&
                            cmd_pid_in != `RTCAC_PID_PRV))
              send(1'b1, `RTCAC_ERR_NSUP, 64'h0);
            else if (~pw_match) begin
              halt_r <= 1'b1; // RULE23
              send(1'b1, `RTCAC_ERR_GEN, 64'h0);
            end else begin
              if (cmd_pid_in == `RTCAC_PID_RD)
                pw_rd_r <= 1'b1;
              if (cmd_pid_in == `RTCAC_PID_WR)
                pw_wr_r <= 1'b1;
              if (cmd_pid_in == `RTCAC_PID_EAS)
                pw_eas_r <= 1'b1;
              if (cmd_pid_in == `RTCAC_PID_PRV)
                pw_prv_r <= 1'b1;
              send(1'b0, 8'h00, 64'h0);
            end
          end
          `RTCAC_C_SQP: begin
            st_r <= ST_QUIET; // RULE9
            pqp_r <= 1'b1;
          end
          `RTCAC_C_RSIG: begin
            sm_r <= SM_SIG; // RULE5
            idx_r <= 8'h00;
            left_r <= 8'h07;
          end
          default: begin
            if (~inv)
              send(1'b1, `RTCAC_ERR_NSUP, 64'h0);
          end
        endcase
      end
      if (cfg_load_in) begin
        page_r <= cfg_page_in;
        rdprot_r <= cfg_rd_counter_protect_flag_in;
        wrprot_r <= cfg_wr_counter_protect_flag_in;
        prv_r <= cfg_privacy_in;
        dstr_r <= cfg_destroyed_in;
        easp_r <= cfg_eas_counter_protect_flag_in;
        if (cfg_pid_in == `RTCAC_PID_RD)
          pwd_rd_r <= cfg_pwd_in;
        if (cfg_pid_in == `RTCAC_PID_WR)
          pwd_wr_r <= cfg_pwd_in;
        if (cfg_pid_in == `RTCAC_PID_EAS)
          pwd_eas_r <= cfg_pwd_in;
        if (cfg_pid_in == `RTCAC_PID_PRV)
          pwd_prv_r <= cfg_pwd_in;
        if (cfg_pid_in == `RTCAC_PID_DST)
          pwd_dst_r <= cfg_pwd_in;
      end
    end
  end

  assign tag_state_out = st_r;
  assign halted_out    = halt_r;
endmodule // rtcac_core
`default_nettype wire

/* File: test/rtcac_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcac_chk #(
  parameter [7:0]  UID_TOP  = 8'ha5,
  parameter [7:0]  MFG_CODE = 8'h5a,
  parameter [7:0]  TAG_TYPE = 8'h3c,
  parameter [39:0] SERIAL   = 40'h0
) (
  // Clock, reset and request
  input wire        clk_in,
  input wire        reset_in,
  input wire        cmd_valid_in,
  input wire [7:0]  cmd_flags_in,
  input wire [7:0]  cmd_code_in,
  input wire [63:0] cmd_uid_in,
  input wire [7:0]  cmd_blk_in,
  // Response and status
  input wire        rsp_valid_out,
  input wire [7:0]  rsp_flags_out,
  input wire [7:0]  rsp_err_out,
  input wire [63:0] rsp_data_out,
  input wire [1:0]  tag_state_out,
  input wire        halted_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire [63:0] uid_w = {UID_TOP, MFG_CODE, TAG_TYPE, SERIAL};
  wire        rq_w  = cmd_valid_in && !halted_out;
  wire        adr_w = rq_w && cmd_flags_in[5] && cmd_uid_in == uid_w;
  property p_rst;
    $fell(reset_in) |-> !rsp_valid_out && !halted_out && tag_state_out == 0;
  endproperty
  property p_err;
    rsp_valid_out && rsp_flags_out[0] |-> rsp_err_out != 8'h00;
  endproperty
  property p_ok;
    rsp_valid_out && !rsp_flags_out[0] |-> rsp_flags_out == 8'h00 &&
      rsp_err_out == 8'h00;
  endproperty
  property p_lock79;
    rq_w && cmd_code_in == 8'h22 && cmd_blk_in == 8'd79 &&
      cmd_flags_in == 8'h00 && tag_state_out == 2'd0 |=>
      rsp_valid_out && rsp_flags_out == 8'h01 && rsp_err_out == 8'h14;
  endproperty
  property p_inv;
    rq_w && cmd_code_in == 8'h01 && cmd_flags_in[2] |=> !rsp_valid_out ||
      (rsp_data_out == uid_w && rsp_data_out[36:35] == 2'b01);
  endproperty
  property p_quiet;
    adr_w && cmd_code_in == 8'h02 |=> !rsp_valid_out && tag_state_out == 2;
  endproperty
  property p_rtr;
    adr_w && cmd_code_in == 8'h26 |=> tag_state_out == 2'd0;
  endproperty
  property p_halt;
    halted_out && $past(halted_out) |-> !rsp_valid_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear");
  a_err: assert property (p_err) else $error("error code zero");
  a_ok: assert property (p_ok) else $error("bad ok response");
  a_lock79: assert property (p_lock79) else $error("lock 79");
  a_inv: assert property (p_inv) else $error("inventory uid");
  a_quiet: assert property (p_quiet) else $error("quiet state");
  a_rtr: assert property (p_rtr) else $error("reset to ready");
  a_halt: assert property (p_halt) else $error("reply while halted");
  c_err: cover property (rsp_valid_out && rsp_flags_out[0]);
  c_inv: cover property (rsp_valid_out && rsp_data_out == uid_w);
  c_quiet: cover property (tag_state_out == 2'd2);
  c_halt: cover property (halted_out);
endmodule // rtcac_chk
bind rtcac_core rtcac_chk #(.UID_TOP(UID_TOP), .MFG_CODE(MFG_CODE),
  .TAG_TYPE(TAG_TYPE), .SERIAL(SERIAL)) chk_u (
  .clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in),
  .cmd_flags_in(cmd_flags_in), .cmd_code_in(cmd_code_in),
  .cmd_uid_in(cmd_uid_in), .cmd_blk_in(cmd_blk_in),
  .rsp_valid_out(rsp_valid_out), .rsp_flags_out(rsp_flags_out),
  .rsp_err_out(rsp_err_out), .rsp_data_out(rsp_data_out),
  .tag_state_out(tag_state_out), .halted_out(halted_out));
`default_nettype wire

/* File: test/rtcac_rdr.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcac_rdr #(
  parameter [63:0] UID = 64'h0,
  parameter [7:0]  MFG = 8'h5a
) (
  // Clock and response
  input  wire         clk_in,
  input  wire         rsp_valid_in,
  input  wire         rsp_last_in,
  // Request
  output logic        cmd_valid_out,
  output logic [7:0]  cmd_flags_out,
  output logic [7:0]  cmd_code_out,
  output logic [7:0]  cmd_mfg_out,
  output logic [63:0] cmd_uid_out,
  output logic [7:0]  cmd_blk_out,
  output logic [7:0]  cmd_cnt_out,
  output logic [31:0] cmd_data_out
);
  initial begin
    cmd_uid_out = UID;
    {cmd_valid_out, cmd_flags_out, cmd_code_out, cmd_mfg_out} = '0;
    {cmd_blk_out, cmd_cnt_out, cmd_data_out} = '0;
  end
  // Waits up to 12 cycles for the last word; early requests drop
  task automatic send(input [7:0] f, c, b, n, input [31:0] d);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_flags_out <= f;
    cmd_code_out  <= c;
    cmd_mfg_out   <= (c >= 8'ha0 && c <= 8'hdf) ? MFG : 8'h00;
    cmd_blk_out   <= b;
    cmd_cnt_out   <= n;
    cmd_data_out  <= d;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_code_out  <= ~c;
    cmd_data_out  <= ~d;
    repeat (12) begin
      @(negedge clk_in);
      if (rsp_valid_in && rsp_last_in) break;
    end
  endtask
endmodule // rtcac_rdr
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam [7:0]  UT = 8'ha5; // Arbitrary value
  localparam [7:0]  MF = 8'h5a; // Arbitrary value
  localparam [7:0]  TT = 8'h3c; // Arbitrary value
  localparam [39:0] SN = 40'h0812345678; // Arbitrary, generation at 36:35
  localparam [255:0] SG = {32'h8d1c0e73, 32'h11f2a4b6, 32'hc03d5e97,
    32'h4a6b2f01, 32'h9e8d7c6b, 32'h05a4b3c2, 32'h7f1e2d3c, 32'hb6a59483};
  localparam [63:0] UID = {UT, MF, TT, SN};
  typedef struct {logic [7:0] f, e; logic [63:0] d, m; logic l;} rtcac_note_t;
  logic clk_in = 0, reset_in = 1, field_in = 1, cfg_load_in = 0, prv = 0;
  logic pq = 0;
  logic [1:0] rd = 0, wp = 0;
  logic [31:0] d [2];
  wire cv, rv, rl, rk, hl;
  wire [7:0] cf, cc, cm, cb, cn, rf, re;
  wire [63:0] cu, rdat;
  wire [31:0] cdat;
  wire [15:0] rx;
  wire [1:0] ts;
  int n_errors = 0, n_checks = 0, cyc = 0, seed = 32'h3e4d;
  rtcac_note_t q[$], nt;
  logic [7:0] cs [3] = '{8'h20, 8'h21, 8'h22};
  rtcac_rdr #(.UID(UID), .MFG(MF)) rdr_u (.clk_in(clk_in), .rsp_valid_in(rv),
    .rsp_last_in(rl), .cmd_valid_out(cv), .cmd_flags_out(cf),
    .cmd_code_out(cc), .cmd_mfg_out(cm), .cmd_uid_out(cu), .cmd_blk_out(cb),
    .cmd_cnt_out(cn), .cmd_data_out(cdat));
  rtcac_core #(.UID_TOP(UT), .MFG_CODE(MF), .TAG_TYPE(TT), .SERIAL(SN),
    .SIGNATURE(SG)) dut_u (.clk_in(clk_in), .reset_in(reset_in),
    .field_in(field_in), .pq_retain_in(pq), .cmd_valid_in(cv),
    .cmd_flags_in(cf), .cmd_code_in(cc), .cmd_mfg_in(cm), .cmd_uid_in(cu),
    .cmd_blk_in(cb), .cmd_cnt_in(cn), .cmd_data_in(cdat), .cmd_pid_in(cn),
    .cmd_afi_in(cn), .cfg_load_in(cfg_load_in), .cfg_page_in(8'd40),
    .cfg_rd_counter_protect_flag_in(rd), .cfg_wr_counter_protect_flag_in(wp), .cfg_privacy_in(prv),
    .cfg_destroyed_in(1'b0), .cfg_eas_counter_protect_flag_in(1'b0), .cfg_pid_in(8'h00),
    .cfg_pwd_in(32'h0), .rsp_valid_out(rv), .rsp_flags_out(rf),
    .rsp_err_out(re), .rsp_data_out(rdat), .rsp_aux_out(rx),
    .rsp_lock_out(rk), .rsp_last_out(rl), .tag_state_out(ts),
    .halted_out(hl));
  initial forever #12.5 clk_in = ~clk_in;
  task chk(input string s, input logic [63:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task exp_r(input [7:0] f, e, input [63:0] dd, m, input l);
    q.push_back('{f, e, dd, m, l});
  endtask
  task cfg(input [1:0] r, input p);
    @(posedge clk_in);
    cfg_load_in <= 1'b1;
    rd <= r;
    prv <= p;
    @(posedge clk_in);
    cfg_load_in <= 1'b0;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(negedge clk_in) begin
    if (rv && q.size() == 0) begin
      chk("stray reply", 64'h0, 64'h1);
    end else if (rv) begin
      nt = q.pop_front();
      chk("flags", nt.f, rf);
      chk("code", nt.e, re);
      chk("data", nt.d & nt.m, rdat & nt.m);
      chk("last", nt.l, rl);
    end
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    exp_r(0, 0, UID, '1, 1);
    rdr_u.send(8'h24, 8'h01, 0, 0, 0);
    for (int i = 0; i < 2; i++) begin
      d[i] = $random(seed);
      exp_r(0, 0, 0, 0, 1);
      rdr_u.send(i ? 8'h40 : 8'h00, 8'h21, 8'd2 + i, 0, d[i]);
    end
    exp_r(0, 0, d[0], 64'hffffffff, 1);
    rdr_u.send(8'h40, 8'h20, 8'd2, 0, 0);
    exp_r(0, 0, d[0], 64'hffffffff, 0);
    exp_r(0, 0, d[1], 64'hffffffff, 1);
    rdr_u.send(8'h00, 8'h23, 8'd2, 8'd1, 0);
    exp_r(1, 8'h14, 0, 0, 1);
    rdr_u.send(8'h00, 8'h22, 8'd79, 0, 0);
    for (int i = 0; i < 8; i++) exp_r(0, 0, SG[32*i+:32], 64'hffffffff, i == 7);
    rdr_u.send(8'h00, 8'hbd, 0, 0, 0);
    cfg(2'b01, 1'b0);
    foreach (cs[i]) begin
      exp_r(1, 8'h0f, 0, 0, 1);
      rdr_u.send(8'h00, cs[i], 8'd2, 0, d[1]);
    end
    exp_r(1, 8'h0f, 0, 0, 1);
    rdr_u.send(8'h00, 8'h23, 8'd39, 8'd1, 0);
    cfg(2'b00, 1'b1);
    rdr_u.send(8'h24, 8'h01, 0, 0, 0);
    exp_r(0, 0, 0, 0, 1);
    rdr_u.send(8'h00, 8'hb2, 0, 0, 0);
    cfg(2'b00, 1'b0);
    rdr_u.send(8'h20, 8'h02, 0, 0, 0);
    chk("state", 2, ts);
    exp_r(0, 0, 0, 0, 1);
    rdr_u.send(8'h20, 8'h26, 0, 0, 0);
    chk("state", 0, ts);
    exp_r(1, 8'h0f, 0, 0, 1);
    rdr_u.send(8'h20, 8'hb3, 0, 8'h01, 32'hffffffff);
    rdr_u.send(8'h00, 8'h20, 8'd2, 0, 0);
    chk("halted", 1, hl);
    field_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    field_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk("halted", 0, hl);
    exp_r(0, 0, d[0], 64'hffffffff, 1);
    rdr_u.send(8'h00, 8'h20, 8'd2, 0, 0);
    repeat (4) @(posedge clk_in);
    chk("pending", 0, q.size());
    finish_test;
  end
endmodule // testbench
`default_nettype wire
